// *** hdl/pss_defines.svh ***
// Timing counts and field positions for the power state sequencer.
// Assumes a 200 MHz core clock; included by bare name.
// Operation
// R01 - Power-down pin low forces off state, retention disabled, all state cleared.
// R02 - Retention sleep powers only the real-time clock domain; recovery memory kept.
// R03 - Light sleep keeps only the real-time clock running; oscillator held off.
// R04 - Any wakeup event from a sleep state enters the wakeup state; from retention sleep the code takes only timer and external-pin events.
// R05 - Wakeup enables oscillator then PLLs, then advances to on.
// R06 - On state delivers the fast clock only to blocks enabled in clock control.
// R07 - Blocks gate finer; processor clock stops on its wait-idle instruction.
// R08 - Every wake-up loads code from external flash before application runs.
// R09 - Rising power-down pin passes through wakeup before on.
// R10 - Retention sleep exits only on timer or external wakeup, via wakeup state.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define PSS_CLK_MHZ          200
`define PSS_XO_SETTLE_NS     1000
`define PSS_PLL_LOCK_NS      500
`define PSS_XO_CYCLES        ((`PSS_XO_SETTLE_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_PLL_CYCLES       ((`PSS_PLL_LOCK_NS * `PSS_CLK_MHZ + 999) / 1000)
`define PSS_CNT_W            12

// ----------------------------------------------------------------------------
// Wakeup source bit positions and block count
// ----------------------------------------------------------------------------
`define PSS_WK_MAC           0
`define PSS_WK_HOST          1
`define PSS_WK_RTC           2
`define PSS_WK_EXT           3
`define PSS_NBLK             8

`endif

// *** hdl/pss_pkg.sv ***
// Types for the power state sequencer.
// Assumes pss_defines.svh is on the include path.
`include "pss_defines.svh"
package pss_pkg;
    typedef enum logic [2:0] {
        PSS_OFF,
        PSS_DEEP,
        PSS_LIGHT,
        PSS_WAKE,
        PSS_ON
    } pss_state_t;

    typedef enum logic [1:0] {
        PSS_W_XO,
        PSS_W_PLL,
        PSS_W_LOAD,
        PSS_W_DONE
    } pss_wphase_t;

    typedef struct packed {
        logic xo_en;
        logic pll_en;
        logic rtc_en;
        logic main_pwr_en;
        logic retain_mem;
    } pss_pwr_t;

    typedef struct packed {
        logic mac;
        logic host;
        logic rtc;
        logic ext;
    } pss_wake_t;
endpackage

// *** hdl/pss_sync.sv ***
// Two-flop synchroniser bank for pin-side inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module pss_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_q;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = d_i;
        s2_d = s1_q;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign q_o = s2_q;
endmodule

// *** hdl/pss_top.sv ***
// Chip power state sequencer: off, retention sleep, light sleep, wakeup, on.
// Assumes an external flash loader that answers load_start_o with load_done_i,
// and an oscillator/PLL pair whose settle times are bounded by the constants.
// Assumes every input other than the two pins is launched from clk_i.
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_top #(
    parameter int XO_CYCLES  = `PSS_XO_CYCLES,
    parameter int PLL_CYCLES = `PSS_PLL_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // Pins
    input  wire logic                 chip_power_down_pin_n_i,
    input  wire logic                 ext_wake_i,
    // On-chip wake sources
    input  wire logic                 mac_wake_i,
    input  wire logic                 host_wake_i,
    input  wire logic                 rtc_timer_wake_i,
    // Sleep requests from firmware
    input  wire logic                 deep_sleep_req_i,
    input  wire logic                 light_sleep_req_i,
    // Clock control
    input  wire logic [`PSS_NBLK-1:0] clk_ctrl_en_i,
    input  wire logic                 cpu_wait_idle_instruction_i,
    input  wire logic                 cpu_irq_i,
    // Flash loader
    output logic                      load_start_o,
    input  wire logic                 load_done_i,
    // Power and clock controls
    output pss_pkg::pss_pwr_t         pwr_o,
    output logic [`PSS_NBLK-1:0]      blk_clk_en_o,
    output logic                      cpu_clk_en_o,
    output logic                      app_run_o,
    output pss_pkg::pss_state_t       state_o
);
    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    // Both pins are asynchronous, so the two-flop delay adds to the power-up and external-pin wake latencies.
    logic [1:0] pin_s;
    logic       pd_n;
    logic       ext_w;

    pss_sync #(.W(2)) u_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    ({chip_power_down_pin_n_i, ext_wake_i}),
        .q_o    (pin_s)
    );
    assign pd_n  = pin_s[1];
    assign ext_w = pin_s[0];

    // Wake sources are gathered into one word so the decode below reads in one place.
    pss_pkg::pss_wake_t wk;
    always_comb begin
        wk.mac  = mac_wake_i;
        wk.host = host_wake_i;
        wk.rtc  = rtc_timer_wake_i;
        wk.ext  = ext_w;
    end

    // ------------------------------------------------------------------------
    // Wake event decode
    // ------------------------------------------------------------------------
    // Retention sleep has the MAC and host powered down, so only the timer and
    // the external pin may end it.
    logic wake_light;
    logic wake_deep;
    assign wake_light = wk.mac || wk.host || wk.rtc || wk.ext; // [R04]
    assign wake_deep  = wk.rtc || wk.ext; // [R10]

    // ------------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------------
    pss_pkg::pss_state_t  st_q;
    pss_pkg::pss_state_t  st_d;
    pss_pkg::pss_wphase_t ph_q;
    pss_pkg::pss_wphase_t ph_d;
    // One counter serves both settle phases because they never overlap.
    logic [`PSS_CNT_W-1:0] cnt_q;
    logic [`PSS_CNT_W-1:0] cnt_d;
    logic                  ld_q;
    logic                  ld_d;
    logic                  cpu_gate_q;
    logic                  cpu_gate_d;

    always_comb begin
        st_d       = st_q;
        ph_d       = ph_q;
        cnt_d      = cnt_q;
        ld_d       = 1'b0;
        cpu_gate_d = cpu_gate_q;
        case (st_q)
            pss_pkg::PSS_OFF: begin
                if (pd_n) begin // [R09]
                    st_d  = pss_pkg::PSS_WAKE;
                    ph_d  = pss_pkg::PSS_W_XO;
                    cnt_d = '0;
                end
            end
            pss_pkg::PSS_DEEP: begin
                if (wake_deep) begin // [R10] [R04]
                    st_d  = pss_pkg::PSS_WAKE;
                    ph_d  = pss_pkg::PSS_W_XO;
                    cnt_d = '0;
                end
            end
            pss_pkg::PSS_LIGHT: begin
                if (wake_light) begin // [R04]
                    st_d  = pss_pkg::PSS_WAKE;
                    ph_d  = pss_pkg::PSS_W_XO;
                    cnt_d = '0;
                end
            end
            pss_pkg::PSS_WAKE: begin
                case (ph_q) // [R05]
                    pss_pkg::PSS_W_XO: begin
                        // The settle times are fixed counts; a crystal that needs longer
                        // than XO_CYCLES to start is not detected here.
                        cnt_d = cnt_q + 1'b1;
                        if (cnt_q == `PSS_CNT_W'(XO_CYCLES - 1)) begin
                            ph_d  = pss_pkg::PSS_W_PLL;
                            cnt_d = '0;
                        end
                    end
                    pss_pkg::PSS_W_PLL: begin
                        cnt_d = cnt_q + 1'b1;
                        if (cnt_q == `PSS_CNT_W'(PLL_CYCLES - 1)) begin
                            ph_d = pss_pkg::PSS_W_LOAD;
                            ld_d = 1'b1; // [R08]
                        end
                    end
                    pss_pkg::PSS_W_LOAD: begin
                        // The loader is started only once the PLLs have settled.
                        if (load_done_i) begin // [R08]
                            ph_d = pss_pkg::PSS_W_DONE;
                        end
                    end
                    pss_pkg::PSS_W_DONE: begin
                        // One spare cycle lets the loader let go of memory first.
                        st_d       = pss_pkg::PSS_ON;
                        cpu_gate_d = 1'b0;
                    end
                    default: ph_d = pss_pkg::PSS_W_XO;
                endcase
            end
            pss_pkg::PSS_ON: begin
                // Wait-idle stops the processor clock until an interrupt arrives.
                if (cpu_irq_i) begin
                    cpu_gate_d = 1'b0; // [R07]
                end else if (cpu_wait_idle_instruction_i) begin
                    cpu_gate_d = 1'b1; // [R07]
                end
                // A deep request wins when both sleep requests arrive together.
                if (deep_sleep_req_i) begin
                    st_d = pss_pkg::PSS_DEEP;
                end else if (light_sleep_req_i) begin
                    st_d = pss_pkg::PSS_LIGHT;
                end
            end
            default: st_d = pss_pkg::PSS_OFF;
        endcase
        // The pin is applied last so that it overrides every branch above.
        if (!pd_n) begin // [R01]
            st_d       = pss_pkg::PSS_OFF;
            ph_d       = pss_pkg::PSS_W_XO;
            cnt_d      = '0;
            ld_d       = 1'b0;
            cpu_gate_d = 1'b0;
        end
    end

    // All sequencer state clears on the synchronous reset, as it does for the pin.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q       <= pss_pkg::PSS_OFF;
            ph_q       <= pss_pkg::PSS_W_XO;
            cnt_q      <= '0;
            ld_q       <= 1'b0;
            cpu_gate_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            ph_q       <= ph_d;
            cnt_q      <= cnt_d;
            ld_q       <= ld_d;
            cpu_gate_q <= cpu_gate_d;
        end
    end

    // ------------------------------------------------------------------------
    // Power and clock outputs
    // ------------------------------------------------------------------------
    // Outputs other than the block enables, which also pass clk_ctrl_en_i straight through, are decoded from registered state only.
    logic in_wake;
    assign in_wake = (st_q == pss_pkg::PSS_WAKE);

    always_comb begin
        // Recovery memory and the timer stay powered in both sleep states; only
        // the off state removes them.
        pwr_o.rtc_en      = (st_q != pss_pkg::PSS_OFF); // [R01]
        pwr_o.retain_mem  = (st_q != pss_pkg::PSS_OFF); // [R02]
        pwr_o.main_pwr_en = (st_q != pss_pkg::PSS_OFF) &&
                            (st_q != pss_pkg::PSS_DEEP); // [R02]
        // Light sleep keeps main power up and stops the oscillator and PLLs, trading
        // some standby current for wakes from the MAC and host as well.
        pwr_o.xo_en       = (st_q == pss_pkg::PSS_ON) || in_wake; // [R03] [R05]
        pwr_o.pll_en      = (st_q == pss_pkg::PSS_ON) ||
                            (in_wake && (ph_q != pss_pkg::PSS_W_XO)); // [R05]
    end

    // Block enables follow the clock control word with no delay while on.
    genvar gi;
    generate
        for (gi = 0; gi < `PSS_NBLK; gi++) begin : g_blk
            assign blk_clk_en_o[gi] = (st_q == pss_pkg::PSS_ON) && clk_ctrl_en_i[gi]; // [R06]
        end
    endgenerate

    assign cpu_clk_en_o = (st_q == pss_pkg::PSS_ON) && !cpu_gate_q; // [R07]
    assign app_run_o    = (st_q == pss_pkg::PSS_ON); // [R08]
    assign load_start_o = ld_q;
    assign state_o      = st_q;
endmodule

// *** dv/pss_top_sva.sv ***
// Port checker for the power state sequencer.
// Assumes a bind into pss_top, sharing its oscillator count.
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_top_sva #(
    parameter int XO_CYCLES = `PSS_XO_CYCLES
) (
    // Clock and reset
    input wire logic                 clk_i,
    input wire logic                 srst_i,
    // Inputs
    input wire logic                 chip_power_down_pin_n_i,
    input wire logic                 mac_wake_i,
    input wire logic                 host_wake_i,
    input wire logic                 rtc_timer_wake_i,
    input wire logic [`PSS_NBLK-1:0] clk_ctrl_en_i,
    input wire logic                 cpu_wait_idle_instruction_i,
    input wire logic                 cpu_irq_i,
    // Outputs
    input wire logic                 load_start_o,
    input wire pss_pkg::pss_pwr_t    pwr_o,
    input wire logic [`PSS_NBLK-1:0] blk_clk_en_o,
    input wire logic                 cpu_clk_en_o,
    input wire logic                 app_run_o,
    input wire pss_pkg::pss_state_t  state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    int   xo_cnt_q;
    logic seen_q;
    always_ff @(posedge clk_i) begin
        if (!srst_i && state_o == pss_pkg::PSS_WAKE && pwr_o.xo_en && !pwr_o.pll_en)
            xo_cnt_q <= xo_cnt_q + 1;
        else
            xo_cnt_q <= 0;
        if (srst_i || app_run_o)
            seen_q <= 1'h0;
        else if (load_start_o)
            seen_q <= 1'h1;
    end
    sequence s_pin_low3;
        !chip_power_down_pin_n_i [*3];
    endsequence
    sequence s_pin_high3;
        chip_power_down_pin_n_i [*3];
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_OFF: assert property (s_pin_low3 |=> state_o == pss_pkg::PSS_OFF && pwr_o == 5'h00)
        else $error("not off with pin low");
    AST_DEEP_PWR: assert property (state_o == pss_pkg::PSS_DEEP |-> pwr_o == 5'h05)
        else $error("bad power in deep sleep");
    AST_LIGHT_PWR: assert property (state_o == pss_pkg::PSS_LIGHT |-> pwr_o == 5'h07)
        else $error("bad power in light sleep");
    AST_WAKE_ENTRY: assert property (s_pin_high3 ##0 (state_o == pss_pkg::PSS_LIGHT &&
        (mac_wake_i || host_wake_i || rtc_timer_wake_i)) |=> state_o == pss_pkg::PSS_WAKE)
        else $error("wake event not taken");
    AST_XO_COUNT: assert property ($rose(pwr_o.pll_en) |-> xo_cnt_q == XO_CYCLES)
        else $error("pll enabled at wrong time");
    AST_ON_CLKS: assert property (blk_clk_en_o ==
        (state_o == pss_pkg::PSS_ON ? clk_ctrl_en_i : 8'h00))
        else $error("block clocks wrong");
    AST_CPU_GATE: assert property (cpu_wait_idle_instruction_i && !cpu_irq_i |=>
        !cpu_clk_en_o)
        else $error("cpu clock not gated");
    AST_RUN_AFTER_LOAD: assert property ($rose(app_run_o) |-> seen_q)
        else $error("run without load");
    AST_ON_FROM_WAKE: assert property ($rose(app_run_o) |->
        $past(state_o) == pss_pkg::PSS_WAKE)
        else $error("on not entered from wakeup");
endmodule

bind pss_top pss_top_sva #(.XO_CYCLES(XO_CYCLES)) sva_u (
    .clk_i(clk_i), .srst_i(srst_i), .chip_power_down_pin_n_i(chip_power_down_pin_n_i),
    .mac_wake_i(mac_wake_i), .host_wake_i(host_wake_i), .rtc_timer_wake_i(rtc_timer_wake_i),
    .clk_ctrl_en_i(clk_ctrl_en_i), .cpu_wait_idle_instruction_i(cpu_wait_idle_instruction_i),
    .cpu_irq_i(cpu_irq_i), .load_start_o(load_start_o), .pwr_o(pwr_o),
    .blk_clk_en_o(blk_clk_en_o), .cpu_clk_en_o(cpu_clk_en_o), .app_run_o(app_run_o),
    .state_o(state_o)
);

// *** dv/pss_flash_model.sv ***
// Flash loader stand-in that answers each load start with a done pulse.
// Assumes the start is a one-cycle pulse; delay_i sets a prompt or slow answer.
`timescale 1ns/1ps
module pss_flash_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Handshake
    input  wire logic       start_i,
    input  wire logic [7:0] delay_i,
    output logic            done_o
);
    logic [8:0] cnt_q;
    // A start during a load restarts it, as a real loader would.
    always_ff @(posedge clk_i) begin
        done_o <= 1'h0;
        if (srst_i)
            cnt_q <= 9'h000;
        else if (start_i)
            cnt_q <= {1'h0, delay_i} + 9'h001;
        else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
            done_o <= (cnt_q == 9'h001);
        end
    end
endmodule

// *** dv/power_state_sequencer_tb.sv ***
// Self-checking bench for the power state sequencer.
// Assumes pss_flash_model answers the flash load handshake.
`timescale 1ns/1ps
module power_state_sequencer_tb;
    logic                clk_i, srst_i, pin_n, ext, mac, host, rtc, deep, light, wfi, irq;
    logic                start, done, cpu_en, run;
    logic [7:0]          ctrl, blk, dly;
    pss_pkg::pss_pwr_t   pwr;
    pss_pkg::pss_state_t st;
    int                  n_errors = 0, total_checks = 0, cyc = 0;

    pss_top #(.XO_CYCLES(2), .PLL_CYCLES(2)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .chip_power_down_pin_n_i(pin_n), .ext_wake_i(ext),
        .mac_wake_i(mac), .host_wake_i(host), .rtc_timer_wake_i(rtc),
        .deep_sleep_req_i(deep), .light_sleep_req_i(light), .clk_ctrl_en_i(ctrl),
        .cpu_wait_idle_instruction_i(wfi), .cpu_irq_i(irq), .load_start_o(start),
        .load_done_i(done), .pwr_o(pwr), .blk_clk_en_o(blk), .cpu_clk_en_o(cpu_en),
        .app_run_o(run), .state_o(st));
    pss_flash_model flash_u (.clk_i(clk_i), .srst_i(srst_i), .start_i(start),
        .delay_i(dly), .done_o(done));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_st(pss_pkg::pss_state_t s, int lim);
        #1;
        for (int i = 0; i < lim && st !== s; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("state", 8'(s), 8'(st));
    endtask
    task automatic pulse(int which);
        @(posedge clk_i);
        case (which)
            0: wfi <= 1'h1;
            1: irq <= 1'h1;
            2: light <= 1'h1;
            default: deep <= 1'h1;
        endcase
        @(posedge clk_i);
        {wfi, irq, light, deep} <= 4'h0;
    endtask
    task automatic set_wake(int src, logic v);
        @(posedge clk_i);
        case (src)
            0: mac <= v;
            1: host <= v;
            2: rtc <= v;
            default: ext <= v;
        endcase
    endtask
    task automatic wake_by(int src);
        set_wake(src, 1'h1);
        wait_st(pss_pkg::PSS_WAKE, 6);
        set_wake(src, 1'h0);
        wait_st(pss_pkg::PSS_ON, 40);
        chk("blk", ctrl, blk);
    endtask

    task automatic t_power_up();
        @(posedge clk_i);
        pin_n <= 1'h1;
        dly <= 8'h1e;
        wait_st(pss_pkg::PSS_WAKE, 6);
        chk("xo_pll", 8'h02, {6'h00, pwr.xo_en, pwr.pll_en});
        repeat (12) @(posedge clk_i);
        wait_st(pss_pkg::PSS_WAKE, 0);
        wait_st(pss_pkg::PSS_ON, 40);
        chk("run", 8'h01, 8'(run));
        @(posedge clk_i);
        dly <= 8'h00;
    endtask
    task automatic t_cpu_gate();
        pulse(0);
        @(posedge clk_i);
        #1;
        chk("cpu_en", 8'h00, 8'(cpu_en));
        chk("blk", ctrl, blk);
        pulse(1);
        @(posedge clk_i);
        #1;
        chk("cpu_en", 8'h01, 8'(cpu_en));
    endtask
    task automatic t_light(int src);
        pulse(2);
        wait_st(pss_pkg::PSS_LIGHT, 4);
        chk("pwr", 8'h07, 8'(pwr));
        chk("blk", 8'h00, blk);
        wake_by(src);
    endtask
    task automatic t_deep(int src);
        pulse(3);
        wait_st(pss_pkg::PSS_DEEP, 4);
        chk("pwr", 8'h05, 8'(pwr));
        set_wake(0, 1'h1);
        set_wake(1, 1'h1);
        repeat (6) @(posedge clk_i);
        wait_st(pss_pkg::PSS_DEEP, 0);
        set_wake(0, 1'h0);
        set_wake(1, 1'h0);
        wake_by(src);
    endtask
    task automatic t_off();
        @(posedge clk_i);
        pin_n <= 1'h0;
        wait_st(pss_pkg::PSS_OFF, 5);
        chk("pwr", 8'h00, 8'(pwr));
    endtask

    initial begin
        srst_i = 1'h1;
        {pin_n, ext, mac, host, rtc, deep, light, wfi, irq} = 9'h000;
        ctrl = 8'ha5;
        dly = 8'h00;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'h0;
        t_power_up();
        t_cpu_gate();
        @(posedge clk_i);
        ctrl <= 8'h3c;
        for (int s = 0; s < 4; s++)
            t_light(s);
        t_deep(2);
        t_deep(3);
        t_off();
        t_power_up();
        pulse(3);
        t_off();
        end_sim();
    end
endmodule
